// ---- pio_far_dev.sv ----
//==================================================================
// Far-end device model
//==================================================================
// Purpose: External parallel device facing the port
// Assumes: Data lines come from the bench, control lines rest high
// Notes: Output bytes are taken on the trailing pulse edge
module pio_far_dev (
    input wire logic clk,
    input wire logic [2:0] pol,
    input wire logic [15:0] din_set,
    input wire logic [15:0] user_dout,
    input wire logic user_hi_ready,
    input wire logic user_lo_ready,
    output logic [15:0] user_din,
    output logic user_data_ready,
    output logic user_data_taken,
    output logic [15:0] got,
    output int hi_cnt,
    output int lo_cnt,
    output int hi_w
);
    timeunit 1ns;
    timeprecision 1ps;
    logic hi_a;
    logic lo_a;
    logic hi_q = 1'b0;
    logic lo_q = 1'b0;
    int w = 0;
    // Data lines follow the bench, control lines stay idle high
    assign user_din = din_set;
    assign user_data_ready = 1'b1;
    assign user_data_taken = 1'b1;
    // Active level after the polarity strap
    assign hi_a = pol[1] ? user_hi_ready : !user_hi_ready;
    assign lo_a = pol[2] ? user_lo_ready : !user_lo_ready;
    initial begin
        hi_cnt = 0;
        lo_cnt = 0;
        hi_w = 0;
        got = 16'h0000;
    end
    always @(posedge clk) begin
        hi_q <= hi_a;
        lo_q <= lo_a;
        w <= hi_a ? w + 1 : 0;
        if (hi_q && !hi_a) begin
            got[15:8] <= user_dout[15:8];
            hi_cnt <= hi_cnt + 1;
            hi_w <= w;
        end
        if (lo_q && !lo_a) begin
            got[7:0] <= user_dout[7:0];
            lo_cnt <= lo_cnt + 1;
        end
    end
endmodule

// ---- pio_pkg.sv ----
//==================================================================
// Package
//==================================================================
// Purpose: Constants and types of the strap-configured parallel port
// Assumes: 125 MHz clock, 16-bit host words
// Notes: Offsets are byte addresses within the decoded block
package pio_pkg;
    localparam int CLK_NS = 8;
    localparam int PULSE_NS = 1000;
    localparam int PULSE_MAX_NS = 5000;
    localparam int PULSE_CYC = PULSE_NS / CLK_NS;
    localparam int PULSE_MAX_CYC = PULSE_MAX_NS / CLK_NS;
    localparam logic [2:0] OFF_STAT = 3'h0;
    localparam logic [2:0] OFF_IN = 3'h2;
    localparam logic [2:0] OFF_OUT = 3'h4;
    localparam int ST_IE_IN = 6;
    localparam int ST_RDY_IN = 7;
    localparam int ST_MNT_IN = 5;
    localparam int ST_IE_OUT = 14;
    localparam int ST_DONE_OUT = 15;
    localparam int ST_MNT_OUT = 13;
    localparam logic [1:0] EDGE_FALL = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_BOTH = 2'h2;
    localparam logic [15:0] STRAP_DIRECT_RST = 16'h0000;
    localparam logic [7:0] STRAP_EDGE_RST = 8'h00;
    localparam logic [9:0] STRAP_ADDR_RST = 10'h200;
    localparam logic [5:0] STRAP_VEC_RST = 6'h18;
    localparam logic [2:0] STRAP_POL_RST = 3'h0;
    typedef struct packed {
        logic hi;
        logic lo;
        logic [15:0] data;
    } pio_out_s;
    typedef enum logic {DR_IDLE, DR_PULSE} pio_drain_e;
endpackage

// ---- pio_port.sv ----
//==================================================================
// Parallel port with strap options
//==================================================================
// Purpose: Host register port, input capture, output handshake pulses
// Assumes: Straps are static levels; host cycles are one-cycle strobes
// Notes: Output words queue in a FIFO ahead of the byte-ready pulses
// Word FIFO with valid and ready on both sides
module pio_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    // Honest full and empty from the count
    assign in_ready = cnt != (AW+1)'(DEPTH);
    assign out_valid = cnt != '0;
    assign out_data = mem[rp];
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp] <= in_data;
        end
    end
    // Pointers and count
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp <= '0;
            rp <= '0;
            cnt <= '0;
        end else begin
            wp <= push ? AW'(wp + 1'b1) : wp;
            rp <= pop ? AW'(rp + 1'b1) : rp;
            cnt <= (AW+1)'(cnt + push - pop);
        end
    end
endmodule
//==================================================================
// Top
//==================================================================
module pio_port
    import pio_pkg::*;
#(
    parameter int PULSE_CYCLES = PULSE_CYC,
    parameter int FIFO_DEPTH = 16
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic bus_sel,
    input wire logic bus_wr,
    input wire logic [1:0] bus_be,
    input wire logic [15:0] bus_addr,
    input wire logic [15:0] bus_wdata,
    output logic [15:0] bus_rdata,
    output logic bus_ready,
    output logic irq_in,
    output logic irq_out,
    output logic [15:0] vec_in,
    output logic [15:0] vec_out,
    input wire logic [15:0] strap_direct,
    input wire logic [7:0] strap_edge,
    input wire logic [15:0] strap_irq_en,
    input wire logic [9:0] strap_addr_sw,
    input wire logic [5:0] strap_vec_sw,
    input wire logic [2:0] strap_pol,
    input wire logic [15:0] user_din,
    input wire logic user_data_ready,
    input wire logic user_data_taken,
    output logic [15:0] user_dout,
    output logic user_accept,
    output logic user_hi_ready,
    output logic user_lo_ready
);
    localparam int PW = $clog2(PULSE_MAX_CYC + 1);
    // Width is clamped to the longest allowed pulse
    localparam logic [PW-1:0] PCYC = PW'((PULSE_CYCLES > PULSE_MAX_CYC) ? PULSE_MAX_CYC : PULSE_CYCLES);
    //==============================================================
    // Reset release and pin synchronisers
    //==============================================================
    logic [1:0] rst_sync;
    wire rst_n = rst_sync[1];
    logic [17:0] s1, s2, s3, filt, prev;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    // Change counts once stages two and three agree
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1 <= '1;
            s2 <= '1;
            s3 <= '1;
            filt <= '1;
            prev <= '1;
        end else begin
            s1 <= {user_data_taken, user_data_ready, user_din};
            s2 <= s1;
            s3 <= s2;
            filt <= (s2 == s3) ? s3 : filt;
            prev <= filt;
        end
    end
    wire [17:0] fall = prev & ~filt;
    wire [17:0] rise = ~prev & filt;
    //==============================================================
    // Address decode
    //==============================================================
    // Straps read live, never stored
    // Switch on is logical zero in the base
    wire hit = bus_sel && bus_addr[12:3] == ~strap_addr_sw;
    // Low octal digit picks the register
    wire sel_stat = hit && bus_addr[2:0] == OFF_STAT;
    wire sel_in = hit && bus_addr[2:0] == OFF_IN;
    wire sel_out = hit && bus_addr[2:0] == OFF_OUT;
    wire [15:0] wmask = {{8{bus_be[1]}}, {8{bus_be[0]}}};
    wire [15:0] wr_one = bus_wdata & wmask;
    logic fifo_rdy;
    // Host waits while the output queue is full
    assign bus_ready = !(sel_out && bus_wr) || fifo_rdy;
    wire wr_stat = sel_stat && bus_wr;
    wire wr_in = sel_in && bus_wr;
    wire wr_out = sel_out && bus_wr && fifo_rdy;
    wire rd_in = sel_in && !bus_wr;
    //==============================================================
    // Input capture
    //==============================================================
    // Edge selection per line, lines below 12 fall only
    function automatic logic edge_hit(input logic [1:0] m, input logic f, input logic r);
        case (m)
            EDGE_RISE: edge_hit = r;
            EDGE_BOTH: edge_hit = f | r;
            default: edge_hit = f;
        endcase
    endfunction
    logic [15:0] set_cap, cap;
    always_comb begin
        set_cap = fall[15:0];
        // Strapped edge for the top four lines
        for (int i = 12; i < 16; i++) begin
            set_cap[i] = edge_hit(strap_edge[2*(i-12) +: 2], fall[i], rise[i]);
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cap <= '0;
        end else begin
            // Ones clear, a new edge wins
            cap <= set_cap | (cap & ~(wr_in ? wr_one : 16'h0));
        end
    end
    // Live low level reads as one
    wire [15:0] in_view = (strap_direct & ~filt[15:0]) | (~strap_direct & cap);
    //==============================================================
    // Status register
    //==============================================================
    logic ie_in, ie_out, rdy_in, done_out, mnt_in, mnt_out;
    wire st_lo = wr_stat && bus_be[0];
    wire st_hi = wr_stat && bus_be[1];
    // Enables, maintenance bits and control-line flags
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ie_in <= 1'b0;
            ie_out <= 1'b0;
            mnt_in <= 1'b0;
            mnt_out <= 1'b0;
            rdy_in <= 1'b0;
            done_out <= 1'b0;
        end else begin
            ie_in <= st_lo ? bus_wdata[ST_IE_IN] : ie_in;
            mnt_in <= st_lo ? bus_wdata[ST_MNT_IN] : mnt_in;
            ie_out <= st_hi ? bus_wdata[ST_IE_OUT] : ie_out;
            mnt_out <= st_hi ? bus_wdata[ST_MNT_OUT] : mnt_out;
            rdy_in <= fall[16] | (st_lo ? bus_wdata[ST_RDY_IN] : rdy_in); // Far-end edge wins
            done_out <= fall[17] | (st_hi ? bus_wdata[ST_DONE_OUT] : done_out);
        end
    end
    // Readable status bits, the rest read zero
    wire [15:0] stat_view = (16'(ie_in) << ST_IE_IN) | (16'(rdy_in) << ST_RDY_IN) |
                            (16'(ie_out) << ST_IE_OUT) | (16'(done_out) << ST_DONE_OUT);
    // Enabled captures share one gated request
    wire any_cap = |(cap & strap_irq_en);
    assign irq_in = ie_in && (any_cap || rdy_in || mnt_in);
    assign irq_out = ie_out && (done_out || mnt_out);
    // Strapped base, bit 2 tells direction
    assign vec_in = {7'h0, strap_vec_sw, 3'h0};
    assign vec_out = {7'h0, strap_vec_sw, 3'h4};
    //==============================================================
    // Read data and output register
    //==============================================================
    logic [15:0] out_reg;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_reg <= '0;
            bus_rdata <= '0;
        end else begin
            out_reg <= wr_out ? (bus_wdata & wmask) | (out_reg & ~wmask) : out_reg;
            bus_rdata <= (sel_stat && !bus_wr) ? stat_view :
                         rd_in ? in_view :
                         (sel_out && !bus_wr) ? out_reg : 16'h0;
        end
    end
    //==============================================================
    // Output queue and byte-ready pulses
    //==============================================================
    pio_out_s q_in, q_out;
    logic q_valid, q_pop, hi_act, lo_act;
    assign q_in = '{hi: bus_be[1], lo: bus_be[0], data: bus_wdata};
    pio_fifo #(.WIDTH($bits(pio_out_s)), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .in_valid(sel_out && bus_wr),
        .in_ready(fifo_rdy),
        .in_data(q_in),
        .out_valid(q_valid),
        .out_ready(q_pop),
        .out_data(q_out)
    );
    pio_drain_e st;
    logic [PW-1:0] dcnt, acnt;
    logic [PW:0] wcnt;
    // Next word only after the previous pulse has ended
    assign q_pop = q_valid && st == DR_IDLE;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= DR_IDLE;
            dcnt <= '0;
            hi_act <= 1'b0;
            lo_act <= 1'b0;
            user_dout <= '0;
        end else begin
            case (st)
                DR_IDLE: begin
                    if (q_pop) begin
                        // Data settles at the leading edge
                        user_dout <= {q_out.hi ? q_out.data[15:8] : user_dout[15:8],
                                      q_out.lo ? q_out.data[7:0] : user_dout[7:0]};
                        hi_act <= q_out.hi;
                        lo_act <= q_out.lo;
                        dcnt <= PCYC;
                        st <= DR_PULSE;
                    end
                end
                DR_PULSE: begin
                    // Pulse lasts exactly the set width
                    dcnt <= PW'(dcnt - 1'b1);
                    if (dcnt == PW'(1)) begin
                        hi_act <= 1'b0;
                        lo_act <= 1'b0;
                        st <= DR_IDLE;
                    end
                end
                default: st <= DR_IDLE;
            endcase
        end
    end
    // Accept pulse follows each input read, byte pulse timed
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            acnt <= '0;
            wcnt <= '0;
        end else begin
            acnt <= rd_in ? PCYC : (acnt != '0) ? PW'(acnt - 1'b1) : acnt;
            wcnt <= hi_act ? (PW+1)'(wcnt + 1'b1) : '0;
        end
    end
    wire acc_act = acnt != '0;
    assign user_accept = strap_pol[0] ? acc_act : ~acc_act;
    assign user_hi_ready = strap_pol[1] ? hi_act : ~hi_act;
    assign user_lo_ready = strap_pol[2] ? lo_act : ~lo_act;
    //==============================================================
    // Checks
    //==============================================================
    sequence s_rdin;
        rd_in;
    endsequence
    sequence s_acc;
        acc_act && (user_accept == strap_pol[0]);
    endsequence
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_read_view: assert property (rd_in |=> bus_rdata == $past(in_view)) else $error("input read mismatch");
    a_live_level: assert property (rd_in && strap_direct[0] |=> bus_rdata[0] == !$past(filt[0]))
        else $error("live line polarity wrong");
    a_cap_fall: assert property (fall[0] |=> cap[0]) else $error("falling edge not captured");
    a_cap_rise: assert property (rise[12] && strap_edge[1:0] == EDGE_RISE |=> cap[12])
        else $error("rising edge not captured");
    a_clear_ones: assert property (wr_in && wr_one[1] && !set_cap[1] |=> !cap[1])
        else $error("write one did not clear");
    a_irq_gate: assert property (ie_in && |(cap & strap_irq_en) |-> irq_in)
        else $error("input request gating wrong");
    a_irq_masked: assert property (!ie_in |-> !irq_in) else $error("request without enable");
    a_vec_step: assert property (vec_out == vec_in + 16'h4 && vec_in[2:0] == 3'h0)
        else $error("vector pair wrong");
    a_addr_base: assert property (sel_stat |-> bus_addr[12:3] == ~strap_addr_sw)
        else $error("decode off base");
    a_pulse_len: assert property ($fell(hi_act) |-> wcnt == (PW+1)'(PCYC))
        else $error("byte pulse width wrong");
    a_accept_seq: assert property (s_rdin |=> s_acc) else $error("accept pulse missing");
    a_pol_out: assert property (user_hi_ready == (strap_pol[1] ? hi_act : !hi_act))
        else $error("pulse polarity wrong");
endmodule

// ---- tb_parallel_io_strap_options.sv ----
//==================================================================
// Testbench
//==================================================================
// Purpose: Random and corner checks of the strap-configured port
// Assumes: Bench drives inputs on the falling edge
// Notes: Short handshake pulses keep the run brief
module tb_parallel_io_strap_options import pio_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PC = 4;
    logic clk = 0, arst_n = 0, bus_sel = 0, bus_wr = 0, stall = 0;
    logic [1:0] bus_be = 2'h3, be;
    logic [15:0] bus_addr = 16'h0000, bus_wdata = 16'h0000, bus_rdata, vec_in, vec_out, user_dout, user_din, got;
    logic [15:0] strap_direct = STRAP_DIRECT_RST, strap_irq_en = 16'h0000, din_set = 16'hffff;
    logic [15:0] q, r, r2, m, base = 16'heff8;
    logic [7:0] strap_edge = STRAP_EDGE_RST;
    logic [9:0] strap_addr_sw = STRAP_ADDR_RST;
    logic [5:0] strap_vec_sw = STRAP_VEC_RST;
    logic [2:0] strap_pol = STRAP_POL_RST;
    logic bus_ready, irq_in, irq_out, user_data_ready, user_data_taken, user_accept, user_hi_ready, user_lo_ready;
    int hi_cnt, lo_cnt, hi_w, h, l, n, fail_count = 0, n_tests = 0;
    integer seed = 43616;
    // Free-running clock, 8 ns period
    always #4 clk = ~clk;
    pio_port #(.PULSE_CYCLES(PC), .FIFO_DEPTH(16)) dut_u (.clk(clk), .arst_n(arst_n),
        .bus_sel(bus_sel), .bus_wr(bus_wr), .bus_be(bus_be), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_rdata(bus_rdata), .bus_ready(bus_ready), .irq_in(irq_in), .irq_out(irq_out),
        .vec_in(vec_in), .vec_out(vec_out), .strap_direct(strap_direct), .strap_edge(strap_edge),
        .strap_irq_en(strap_irq_en), .strap_addr_sw(strap_addr_sw), .strap_vec_sw(strap_vec_sw),
        .strap_pol(strap_pol), .user_din(user_din), .user_data_ready(user_data_ready),
        .user_data_taken(user_data_taken), .user_dout(user_dout), .user_accept(user_accept),
        .user_hi_ready(user_hi_ready), .user_lo_ready(user_lo_ready));
    pio_far_dev far_u (.clk(clk), .pol(strap_pol), .din_set(din_set), .user_dout(user_dout),
        .user_hi_ready(user_hi_ready), .user_lo_ready(user_lo_ready), .user_din(user_din),
        .user_data_ready(user_data_ready), .user_data_taken(user_data_taken), .got(got),
        .hi_cnt(hi_cnt), .lo_cnt(lo_cnt), .hi_w(hi_w));
    //==================================================================
    // Helpers
    //==================================================================
    // Compare and count
    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Counts and verdict, then end of run
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // A wait that ran out of time
    task automatic give_up(input string nm);
        fail_count++;
        $display("mismatch %s expected done seen timeout", nm);
        report_and_stop();
    endtask
    // One host cycle, held while the port is not ready
    task automatic bus(input logic wr, input logic [15:0] a, input logic [15:0] d, input logic [1:0] b);
        int t;
        t = 0;
        @(negedge clk);
        bus_sel = 1;
        bus_wr = wr;
        bus_addr = a;
        bus_wdata = d;
        bus_be = b;
        #1;
        stall = 0;
        while (bus_ready !== 1'b1) begin
            stall = 1;
            t++;
            if (t > 200) give_up("bus ready");
            @(negedge clk);
            #1;
        end
        @(negedge clk);
        bus_sel = 0;
        q = bus_rdata;
    endtask
    // Input pins pass a synchroniser before capture
    task automatic settle;
        repeat (10) @(negedge clk);
    endtask
    // Block base from the address switches, on meaning zero
    function automatic logic [15:0] base_of(input logic [9:0] sw);
        return {3'h0, ~sw, 3'h0};
    endfunction
    // Capture bits 15:12 after a fall or a rise of those lines
    function automatic logic [15:0] edge_exp(input logic [7:0] e, input logic rise);
        logic [15:0] v;
        v = 16'h0000;
        for (int i = 0; i < 4; i++) begin
            v[12+i] = rise ? (e[2*i+:2] == EDGE_RISE || e[2*i+:2] == EDGE_BOTH) : (e[2*i+:2] != EDGE_RISE);
        end
        return v;
    endfunction
    //==================================================================
    // Main sequence
    //==================================================================
    initial begin
        repeat (2) @(negedge clk);
        arst_n = 1;
        repeat (3) @(negedge clk);
        check("accept idle", 16'(user_accept), 16'h0001);
        check("irq out idle", 16'(irq_out), 16'h0000);
        din_set = 16'h0000;
        settle();
        din_set = 16'hffff;
        settle();
        bus(0, 16'heffa, 0, 3);
        check("default capture", q, 16'hffff);
        bus(1, 16'heffa, 16'hffff, 3);
        bus(0, 16'heffa, 0, 3);
        check("clear by ones", q, 16'h0000);
        $display("test defaults done");
        for (int k = 0; k < 4; k++) begin
            @(negedge clk);
            strap_vec_sw = 6'($random(seed));
            #1;
            check("vector in", vec_in, {7'h0, strap_vec_sw, 3'h0});
            check("vector out", vec_out, {7'h0, strap_vec_sw, 3'h4});
        end
        strap_vec_sw = STRAP_VEC_RST;
        #1;
        check("vector 300", vec_in, 16'h00c0);
        $display("test vectors done");
        for (int k = 0; k < 5; k++) begin
            strap_addr_sw = (k == 0) ? STRAP_ADDR_RST : 10'($random(seed));
            base = base_of(strap_addr_sw);
            r = 16'($random(seed));
            bus(1, base | 16'h0004, r, 3);
            bus(0, base | 16'h0004, 0, 3);
            check("output readback", q, r);
            bus(0, base | 16'h0006, 0, 3);
            check("unmapped offset", q, 16'h0000);
            bus(0, (base ^ 16'h0008) | 16'h0004, 0, 3);
            check("other block", q, 16'h0000);
        end
        strap_addr_sw = STRAP_ADDR_RST;
        base = 16'heff8;
        $display("test address done");
        for (int k = 0; k < 4; k++) begin
            strap_pol = 3'($random(seed));
            strap_direct = (k == 0) ? 16'hffff : 16'($random(seed));
            r = 16'($random(seed));
            r2 = 16'($random(seed));
            din_set = r;
            settle();
            din_set = r2;
            settle();
            m = ~r | (r & ~r2);
            bus(0, base | 16'h0002, 0, 3);
            check("input view", q, (strap_direct & ~r2) | (~strap_direct & m));
            n = 0;
            while (user_accept === strap_pol[0] && n < 20) begin
                n++;
                @(negedge clk);
            end
            check("accept width", 16'(n), 16'(PC));
            check("accept rest", 16'(user_accept), 16'(!strap_pol[0]));
            bus(1, base | 16'h0002, 16'hffff, 3);
            din_set = 16'hffff;
            strap_direct = 16'h0000;
            settle();
            bus(0, base | 16'h0002, 0, 3);
            check("rise no capture", q, 16'h0000);
        end
        $display("test input done");
        for (int k = 0; k < 3; k++) begin
            strap_edge = 8'hc9;
            for (int j = 0; j < 4 && k > 0; j++) begin
                strap_edge[2*j+:2] = 2'(($random(seed) & 32'h7fffffff) % 3);
            end
            din_set = 16'h0fff;
            settle();
            bus(0, base | 16'h0002, 0, 3);
            check("fall capture", q, edge_exp(strap_edge, 1'b0));
            bus(1, base | 16'h0002, 16'hffff, 3);
            din_set = 16'hffff;
            settle();
            bus(0, base | 16'h0002, 0, 3);
            check("rise capture", q, edge_exp(strap_edge, 1'b1));
            bus(1, base | 16'h0002, 16'hffff, 3);
        end
        strap_edge = STRAP_EDGE_RST;
        $display("test edges done");
        strap_irq_en = 16'($random(seed));
        bus(1, base, 16'h0040, 2'h1);
        bus(0, base, 0, 3);
        check("status ie", q, 16'h0040);
        for (int k = 0; k < 4; k++) begin
            r = 16'($random(seed));
            m = 16'h0001 << r[3:0];
            if (k == 0) strap_irq_en = strap_irq_en | m;
            if (k == 1) strap_irq_en = strap_irq_en & ~m;
            din_set = ~m;
            settle();
            check("irq set", 16'(irq_in), 16'(|(m & strap_irq_en)));
            bus(1, base, 16'h0000, 2'h1);
            check("irq gated", 16'(irq_in), 16'h0000);
            bus(1, base, 16'h0040, 2'h1);
            check("irq again", 16'(irq_in), 16'(|(m & strap_irq_en)));
            bus(1, base | 16'h0002, 16'hffff, 3);
            din_set = 16'hffff;
            settle();
            check("irq cleared", 16'(irq_in), 16'h0000);
        end
        bus(1, base, 16'h0000, 2'h1);
        $display("test interrupt done");
        for (int k = 0; k < 4; k++) begin
            strap_pol = 3'($random(seed));
            r = 16'($random(seed));
            be = 2'(1 + k % 3);
            h = hi_cnt;
            l = lo_cnt;
            bus(1, base | 16'h0004, r, be);
            n = 0;
            while (!(hi_cnt == h + be[1] && lo_cnt == l + be[0]) || n < PC + 4) begin
                n++;
                if (n > 60) give_up("byte pulses");
                @(negedge clk);
            end
            if (be[1]) check("high byte", {8'h00, got[15:8]}, {8'h00, r[15:8]});
            if (be[0]) check("low byte", {8'h00, got[7:0]}, {8'h00, r[7:0]});
            if (be[1]) check("ready width", 16'(hi_w), 16'(PC));
            check("high rest", 16'(user_hi_ready), 16'(!strap_pol[1]));
            check("low rest", 16'(user_lo_ready), 16'(!strap_pol[2]));
        end
        $display("test output done");
        h = hi_cnt;
        n = 0;
        stall = 0;
        while (!stall && n < 60) begin
            r = 16'($random(seed));
            bus(1, base | 16'h0004, r, 3);
            n++;
        end
        check("fifo refused", 16'(stall), 16'h0001);
        l = 0;
        while (hi_cnt != h + n) begin
            l++;
            if (l > 1000) give_up("fifo drain");
            @(negedge clk);
        end
        check("last word", got, r);
        bus(0, base | 16'h0004, 0, 3);
        check("output last", q, r);
        $display("test fifo done");
        report_and_stop();
    end
endmodule
